// ===== common/rnl_pkg.sv
/*
 * Shared constants and carrier types for the reservation notification log.
 * Assumes one controller clock and the controller reset for all users.
 */
`default_nettype none
package rnl_pkg;
	localparam logic [7:0] RNL_LOG_ID = 8'h80;
	localparam logic [7:0] RNL_STS_OK = 8'h00;
	localparam logic [7:0] RNL_STS_BAD_LOG = 8'h09;
	localparam logic [7:0] RNL_KIND_EMPTY = 8'h00;
	localparam logic [7:0] RNL_KIND_REG_PREEMPT = 8'h01;
	localparam logic [7:0] RNL_KIND_RES_RELEASE = 8'h02;
	localparam logic [7:0] RNL_KIND_RES_PREEMPT = 8'h03;
	localparam logic [7:0] RNL_REMAIN_MAX = 8'hFF;
	localparam int RNL_PAGE_BYTES = 64;
	localparam int RNL_PAGE_BITS = RNL_PAGE_BYTES * 8;
	localparam logic [5:0] RNL_LAST_BYTE = 6'h3F;
	localparam logic [5:0] RNL_KIND_BYTE = 6'h08;
	localparam logic [5:0] RNL_REMAIN_BYTE = 6'h09;
	localparam logic [5:0] RNL_RSVD_LO_A = 6'h0A;
	localparam logic [5:0] RNL_RSVD_LO_B = 6'h0B;
	localparam logic [5:0] RNL_RSVD_HI = 6'h10;
	localparam int RNL_QUEUE_AW = 9;
	localparam logic [9:0] RNL_QUEUE_DEPTH = 10'h200;
	localparam logic [63:0] RNL_COUNT_RESET = 64'h0;

	typedef struct packed {
		logic [7:0] kind;
		logic [31:0] nsid;
	} rnl_notif_type;

	typedef struct packed {
		logic [63:0] count;
		logic [7:0] kind;
		logic [31:0] nsid;
	} rnl_entry_type;

	typedef struct packed {
		logic valid;
		logic [7:0] status;
	} rnl_cpl_type;
endpackage
`default_nettype wire

// ===== logic/rnl_log.sv
/*
 * Reservation notification log: queues unmasked notifications and streams
 * one 64-byte page per log read, then posts a completion.
 * Assumes all inputs are synchronous to sys_clk and that the data sink
 * accepts a byte whenever bufReady is high.
 */
// Contract
// - Serve the reservation notification page under log identifier 80h.
// - Every unmasked notification on any namespace creates a log entry; the code drops it while the queue holds 512 entries or its kind is not 1, 2 or 3.
// - One read returns one page from a single controller-wide queue.
// - Bytes 7..0 carry the 64-bit identifying count of the notification.
// - Count is zero after reset and advances once per new entry.
// - Count wraps to zero after its maximum when another entry arrives.
// - Count zero in a returned page means an empty entry.
// - Byte 8 holds kind 1, 2 or 3; codes 4..255 never produced.
// - Read with nothing pending returns type 0 and an all-zero page.
// - Byte 9 gives unread pages left, excluding the one returned.
// - More than 255 pages left reports 255.
// - Byte 9 zero means nothing waits after the current page.
// - Bytes 15..12 carry the namespace identifier of the notification.
// - Post the completion only after the page reached host memory.
// - An unknown log identifier completes with status 9h.
`timescale 1ns/1ps
`default_nettype none
module rnl_log (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic notifValid,
	input wire logic notifMasked,
	input wire rnl_pkg::rnl_notif_type notif,
	input wire logic reqValid,
	input wire logic [7:0] reqLogId,
	output logic reqReady,
	input wire logic bufReady,
	output logic byteValid,
	output logic [7:0] pageByte,
	output logic [5:0] byteIdx,
	output rnl_pkg::rnl_cpl_type cpl,
	output logic [63:0] logCount
);
	import rnl_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} rnl_state_type;

	rnl_state_type state_r;
	rnl_entry_type queue_r [0:(1 << RNL_QUEUE_AW) - 1];
	logic [RNL_QUEUE_AW-1:0] wrPtr_r;
	logic [RNL_QUEUE_AW-1:0] rdPtr_r;
	logic [9:0] occ_r;
	logic [9:0] occ_nxt;
	logic [63:0] logCount_r;
	logic [RNL_PAGE_BITS-1:0] page_r;
	logic [5:0] idx_r;
	logic emptyPage_r;
	logic [7:0] remain;
	logic kindLegal;
	logic push;
	logic take;
	logic beat;
	logic lastBeat;
	logic pop;
	rnl_cpl_type cpl_r;
	rnl_entry_type head;

	assign kindLegal = notif.kind == RNL_KIND_REG_PREEMPT
		|| notif.kind == RNL_KIND_RES_RELEASE
		|| notif.kind == RNL_KIND_RES_PREEMPT;
	// Unmasked entries only.
	// A full queue drops the event; it gets no count, so counts stay dense.
	assign push = clkEn && notifValid && !notifMasked && kindLegal
		&& occ_r != RNL_QUEUE_DEPTH;
	assign take = clkEn && reqValid && state_r == ST_IDLE;
	assign beat = clkEn && state_r == ST_SEND && bufReady;
	assign lastBeat = beat && idx_r == RNL_LAST_BYTE;
	assign pop = lastBeat && !emptyPage_r;
	assign head = queue_r[rdPtr_r];

	assign remain = (occ_r - 10'h001 > {2'b00, RNL_REMAIN_MAX}) ? RNL_REMAIN_MAX
		: 8'((occ_r - 10'h001));

	// Natural wrap of the 64-bit sum.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			logCount_r <= RNL_COUNT_RESET;
		end else if (push) begin
			logCount_r <= logCount_r + 64'h1;
		end
	end

	// Arrival order kept by the ring.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			queue_r[wrPtr_r] <= '{count: logCount_r + 64'h1, kind: notif.kind,
				nsid: notif.nsid};
		end
	end

	always_comb begin
		occ_nxt = occ_r;
		if (push && !pop) begin
			occ_nxt = occ_r + 10'h001;
		end else if (pop && !push) begin
			occ_nxt = occ_r - 10'h001;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			occ_r <= 10'h000;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			occ_r <= occ_nxt;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else if (clkEn) begin
			case (state_r)
				ST_IDLE: begin
					if (take && reqLogId == RNL_LOG_ID) begin
						state_r <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (lastBeat) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Page image is frozen at the read so later arrivals cannot tear it.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			page_r <= '0;
			emptyPage_r <= 1'b1;
		end else if (take && reqLogId == RNL_LOG_ID) begin
			emptyPage_r <= occ_r == 10'h000;
			if (occ_r == 10'h000) begin
				page_r <= '0;
			end else begin
				page_r <= {384'h0, head.nsid, 16'h0000, remain, head.kind, head.count};
			end
		end else if (beat) begin
			page_r <= page_r >> 8;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			idx_r <= 6'h00;
		end else if (take) begin
			idx_r <= 6'h00;
		end else if (beat) begin
			idx_r <= idx_r + 6'h01;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cpl_r <= '0;
		end else if (clkEn) begin
			cpl_r <= '0;
			if (take && reqLogId != RNL_LOG_ID) begin
				cpl_r <= '{valid: 1'b1, status: RNL_STS_BAD_LOG};
			end
			if (lastBeat) begin
				cpl_r <= '{valid: 1'b1, status: RNL_STS_OK};
			end
		end
	end

	assign reqReady = state_r[0];
	assign byteValid = state_r[1];
	assign pageByte = page_r[7:0];
	assign byteIdx = idx_r;
	assign cpl = cpl_r;
	assign logCount = logCount_r;

	sequence s_read_taken;
		take && reqLogId == RNL_LOG_ID;
	endsequence

	sequence s_last_accept;
		lastBeat;
	endsequence

	sequence s_full_read;
		s_read_taken ##0 (occ_r != 10'h000);
	endsequence

	a_count_step: assert property (@(posedge sys_clk) disable iff (reset)
		push |=> logCount_r == $past(logCount_r) + 64'h1)
		else $error("log count did not advance by one");

	a_masked_drop: assert property (@(posedge sys_clk) disable iff (reset)
		(clkEn && notifValid && notifMasked) |=> logCount_r == $past(logCount_r))
		else $error("masked notification created an entry");

	a_kind_legal: assert property (@(posedge sys_clk) disable iff (reset)
		(byteValid && idx_r == RNL_KIND_BYTE) |-> pageByte <= RNL_KIND_RES_PREEMPT)
		else $error("reserved notification kind produced");

	a_empty_zero: assert property (@(posedge sys_clk) disable iff (reset)
		(s_read_taken ##0 (occ_r == 10'h000)) |=> byteValid && page_r == '0)
		else $error("empty page not all zero");

	a_remain_sat: assert property (@(posedge sys_clk) disable iff (reset)
		(s_read_taken ##0 (occ_r > 10'h100)) |=> page_r[79:72] == RNL_REMAIN_MAX)
		else $error("remaining count not saturated");

	a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (reset)
		(byteValid && (idx_r >= RNL_RSVD_HI || idx_r == RNL_RSVD_LO_A
		|| idx_r == RNL_RSVD_LO_B)) |-> pageByte == 8'h00)
		else $error("reserved byte not zero");

	// A frozen clock enable holds an earlier completion, so that case is let through.
	a_cpl_after: assert property (@(posedge sys_clk) disable iff (reset)
		(cpl_r.valid && cpl_r.status == RNL_STS_OK) |-> $past(lastBeat) || !$past(clkEn))
		else $error("completion before page transfer");

	a_bad_id: assert property (@(posedge sys_clk) disable iff (reset)
		(take && reqLogId != RNL_LOG_ID) |=> cpl_r.valid
		&& cpl_r.status == RNL_STS_BAD_LOG && state_r == ST_IDLE)
		else $error("bad identifier not refused");

	a_pop_once: assert property (@(posedge sys_clk) disable iff (reset)
		(s_last_accept ##0 !emptyPage_r ##0 !push) |=> occ_r == $past(occ_r) - 10'h001)
		else $error("returned page not removed");

	a_empty_keep: assert property (@(posedge sys_clk) disable iff (reset)
		(s_last_accept ##0 emptyPage_r ##0 !push) |=> occ_r == $past(occ_r))
		else $error("empty page removed an entry");

	a_read_start: assert property (@(posedge sys_clk) disable iff (reset)
		s_read_taken |=> byteValid && idx_r == 6'h00 && !reqReady)
		else $error("page stream did not start");

	a_count_field: assert property (@(posedge sys_clk) disable iff (reset)
		s_full_read |=> page_r[63:0] == $past(head.count))
		else $error("page count field wrong");

	a_kind_field: assert property (@(posedge sys_clk) disable iff (reset)
		s_full_read |=> page_r[71:64] == $past(head.kind))
		else $error("page kind field wrong");

	a_ns_field: assert property (@(posedge sys_clk) disable iff (reset)
		s_full_read |=> page_r[127:96] == $past(head.nsid))
		else $error("page namespace field wrong");

	a_remain_exact: assert property (@(posedge sys_clk) disable iff (reset)
		(s_full_read ##0 (occ_r <= 10'h100)) |=> {2'b00, page_r[79:72]} + 10'h001
		== $past(occ_r))
		else $error("remaining count wrong");

	a_illegal_drop: assert property (@(posedge sys_clk) disable iff (reset)
		(clkEn && notifValid && !notifMasked && !kindLegal)
		|=> logCount_r == $past(logCount_r))
		else $error("reserved kind created an entry");

	a_ok_cpl: assert property (@(posedge sys_clk) disable iff (reset)
		s_last_accept |=> cpl_r.valid && cpl_r.status == RNL_STS_OK && reqReady)
		else $error("completion missing after page");

	a_byte_step: assert property (@(posedge sys_clk) disable iff (reset)
		beat |=> idx_r == $past(idx_r) + 6'h01)
		else $error("byte index skipped");

	a_page_shift: assert property (@(posedge sys_clk) disable iff (reset)
		beat |=> page_r == ($past(page_r) >> 8))
		else $error("page bytes out of order");

	a_bad_quiet: assert property (@(posedge sys_clk) disable iff (reset)
		(take && reqLogId != RNL_LOG_ID) |=> !byteValid && idx_r == 6'h00)
		else $error("bad identifier streamed data");

	// Clock enable low must leave every register untouched.
	a_freeze_hold: assert property (@(posedge sys_clk) disable iff (reset)
		!clkEn |=> $stable(state_r) && $stable(idx_r) && $stable(logCount_r)
		&& $stable(occ_r) && $stable(page_r) && $stable(cpl_r))
		else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ===== tb/rnl_host.sv
/*
 * Host side model: accepts streamed log page bytes into a page image.
 * Assumes the block presents bytes with an index and holds them until taken.
 */
`timescale 1ns/1ps
`default_nettype none
module rnl_host (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic clr,
	input wire logic byteValid,
	input wire logic [7:0] pageByte,
	input wire logic [5:0] byteIdx,
	output logic bufReady,
	output logic [511:0] page
);
	// A slow host stalls every other cycle to stretch each byte.
	always @(posedge sys_clk) begin
		bufReady <= !slow || !bufReady;
		if (clr) begin
			page <= '1;
		end else if (byteValid && bufReady) begin
			page[byteIdx*8 +: 8] <= pageByte;
		end
	end
endmodule
`default_nettype wire

// ===== tb/rnl_log_tb.sv
/*
 * Self-checking bench for the reservation notification log.
 * Assumes the host model in rnl_host.sv and the shared package.
 */
`timescale 1ns/1ps
`default_nettype none
module rnl_log_tb;
	import rnl_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic notifValid = 1'b0;
	logic notifMasked = 1'b0;
	logic reqValid = 1'b0;
	logic slow = 1'b0;
	logic clr = 1'b0;
	logic clkEn = 1'b1;
	rnl_notif_type notif = '0;
	logic [7:0] reqLogId = 8'h00;
	logic [7:0] pageByte;
	logic reqReady;
	logic byteValid;
	logic bufReady;
	logic [5:0] byteIdx;
	rnl_cpl_type cpl;
	logic [63:0] logCount;
	logic [511:0] page;
	int failures = 0;
	int n_checks = 0;
	always #50 sys_clk = ~sys_clk;
	rnl_log rnl_log_i (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
		.notifValid(notifValid), .notifMasked(notifMasked), .notif(notif),
		.reqValid(reqValid), .reqLogId(reqLogId), .reqReady(reqReady),
		.bufReady(bufReady), .byteValid(byteValid), .pageByte(pageByte),
		.byteIdx(byteIdx), .cpl(cpl), .logCount(logCount));
	rnl_host rnl_host_i (.sys_clk(sys_clk), .slow(slow), .clr(clr),
		.byteValid(byteValid), .pageByte(pageByte), .byteIdx(byteIdx),
		.bufReady(bufReady), .page(page));
	task finish_test;
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input logic [511:0] seen, input logic [511:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	function automatic logic [511:0] pe(logic [63:0] c, logic [7:0] k, logic [7:0] r,
		logic [31:0] ns);
		return {384'h0, ns, 16'h0, r, k, c};
	endfunction
	task rd(input logic [7:0] id, input logic [7:0] sts);
		int i;
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqLogId <= id;
		clr <= 1'b1;
		@(posedge sys_clk);
		reqValid <= 1'b0;
		clr <= 1'b0;
		for (i = 0; i < 300; i++) begin
			@(negedge sys_clk);
			if (cpl.valid === 1'b1) begin
				break;
			end
		end
		if (i == 300) begin
			failures++;
			finish_test;
		end else begin
			chk(cpl.status, sts);
			chk({reqReady, byteValid}, 2'b10);
		end
	endtask
	task nt(input logic [7:0] k, input logic [31:0] ns, input logic m);
		@(posedge sys_clk);
		notifValid <= 1'b1;
		notif <= {k, ns};
		notifMasked <= m;
		@(posedge sys_clk);
		notifValid <= 1'b0;
	endtask
	task s_empty_bad;
		rd(RNL_LOG_ID, RNL_STS_OK);
		chk(page, '0);
		rd(8'h05, RNL_STS_BAD_LOG);
		rd(8'h81, RNL_STS_BAD_LOG);
	endtask
	task s_queue;
		nt(RNL_KIND_REG_PREEMPT, 32'h11, 1'b1);
		nt(8'h04, 32'h12, 1'b0);
		nt(RNL_KIND_REG_PREEMPT, 32'hA1B2C3D4, 1'b0);
		nt(RNL_KIND_RES_RELEASE, 32'h22, 1'b0);
		nt(RNL_KIND_RES_PREEMPT, 32'h33, 1'b0);
		@(negedge sys_clk);
		chk(logCount, 64'h3);
		slow <= 1'b1;
		rd(RNL_LOG_ID, RNL_STS_OK);
		chk(page, pe(64'h1, 8'h01, 8'h02, 32'hA1B2C3D4));
		slow <= 1'b0;
		rd(RNL_LOG_ID, RNL_STS_OK);
		chk(page, pe(64'h2, 8'h02, 8'h01, 32'h22));
		rd(RNL_LOG_ID, RNL_STS_OK);
		chk(page, pe(64'h3, 8'h03, 8'h00, 32'h33));
		rd(RNL_LOG_ID, RNL_STS_OK);
		chk(page, '0);
	endtask
	task s_sat;
		@(posedge sys_clk);
		notifValid <= 1'b1;
		notif <= {RNL_KIND_RES_RELEASE, 32'hA5};
		repeat (300) @(posedge sys_clk);
		notifValid <= 1'b0;
		@(negedge sys_clk);
		chk(logCount, 64'd303);
		rd(RNL_LOG_ID, RNL_STS_OK);
		chk(page, pe(64'h4, 8'h02, RNL_REMAIN_MAX, 32'hA5));
	endtask
	task s_freeze;
		@(posedge sys_clk);
		clkEn <= 1'b0;
		nt(RNL_KIND_REG_PREEMPT, 32'h44, 1'b0);
		@(negedge sys_clk);
		chk(logCount, 64'd303);
		@(posedge sys_clk);
		clkEn <= 1'b1;
		rd(RNL_LOG_ID, RNL_STS_OK);
		chk(page, pe(64'h5, 8'h02, RNL_REMAIN_MAX, 32'hA5));
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		s_empty_bad;
		s_queue;
		s_sat;
		s_freeze;
		finish_test;
	end
endmodule
`default_nettype wire
